// file: rtl/aocl_pkg.sv
package aocl_pkg;
    // register addresses
    localparam logic [4:0]  ADDR_CONV      = 5'h00;
    localparam logic [4:0]  ADDR_MAP_FIRST = 5'h09;
    localparam logic [4:0]  ADDR_KEY       = 5'h1f;
    // controller-side register offsets
    localparam logic [3:0]  OFS_CTRL       = 4'h0;
    localparam logic [3:0]  OFS_STAT       = 4'h1;
    localparam logic [3:0]  OFS_DATA       = 4'h2;
    localparam logic [3:0]  OFS_CRC        = 4'h3;
    localparam logic [3:0]  OFS_MAPWR      = 4'h4;
    // key and checksum constants
    localparam logic [7:0]  UNLOCK_KEY     = 8'ha5;
    localparam logic [15:0] CRC_POLY       = 16'h8005;
    localparam logic [15:0] CRC_INIT       = 16'h0000;
    localparam logic [15:0] CRC_GOOD       = 16'h0000;
    localparam int          DATA_W         = 24;
    localparam int          MAP_DEPTH      = 32;
    localparam int          MAP_PERIODS    = 10;
    localparam logic [3:0]  MAP_PERIODS_M1 = 4'h9;
    // clock division
    localparam int          SYS_CLK_HZ     = 10_000_000;
    localparam int          DIVIDED_DIGITAL_CLOCK_HZ       = 2_500_000;
    localparam int          DIVIDED_DIGITAL_CLOCK_DIV      = SYS_CLK_HZ / DIVIDED_DIGITAL_CLOCK_HZ;
    localparam int          SCK_HALF       = 2;
    // status bit positions
    localparam int          BIT_CRC_EN     = 0;
    localparam int          BIT_WIDTH32    = 1;
    localparam int          BIT_INT_EN     = 2;
    localparam int          BIT_EXTERNAL_CLOCK_SELECT     = 3;

    // crc-16 update, one bit, msb first
    function automatic logic [15:0] aocl_crc_bit(input logic [15:0] c, input logic b);
        aocl_crc_bit = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : CRC_INIT);
    endfunction : aocl_crc_bit

    typedef enum logic [4:0] {
        AOCL_IDLE = 5'b00001,
        AOCL_CMD  = 5'b00010,
        AOCL_DATA = 5'b00100,
        AOCL_CRC  = 5'b01000,
        AOCL_DONE = 5'b10000
    } aocl_state_t;
endpackage : aocl_pkg

// file: rtl/aocl_if.sv
`timescale 1ns/1ps
interface aocl_if;
    logic       sck;            // serial clock from host (sampled)
    logic       cs_n;           // chip select, active low
    logic       sdi;            // host to device data
    logic       sdo;            // device to host data
    logic       sdo_oe;         // device drives sdo
    logic       sample_ready_pin_n; // active-low ready / map alarm
    logic       interface_select_pin; // 0 spi, 1 two-wire
    modport device (input sck, cs_n, sdi, interface_select_pin,
                    output sdo, sdo_oe, sample_ready_pin_n);
    modport host (output sck, cs_n, sdi, interface_select_pin,
                  input sdo, sdo_oe, sample_ready_pin_n);
endinterface : aocl_if

// file: rtl/aocl_device.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
// Behaviour
// - first latch captures result on ready event
// - second latch freezes result at read start
// - host reads all result bits before next
// - host waits output-valid delay after ready edge
// - ready flag exposed, reads 0 when fresh; here the flag register is kept internal and is not read out
// - checksum appended after each read set
// - checksum polynomial is 0x8005
// - 32-bit format pads two zero bytes
// - checksum value always sixteen bits
// - host keeps data width matching checksum width
// - host expects zero remainder over sequence
// - key register unlocks writes at 0xa5
// - locked map ignores writes except key
// - map checksum runs only while locked
// - map checksum every ten divided-clock periods
// - map checksum covers 0x09 to 0x1f
// - reset clears map checksum field
// - first locked checksum becomes reference
// - mismatch with interrupt enable holds pin low
// - powers up unlocked with no alarm
// - mode pin selects interface when external_clock_select
// - interface choice latched at reset release
// - locked alarm latches ready pin low
module aocl_device #(
    parameter int DIVIDED_DIGITAL_CLOCK_DIV = aocl_pkg::DIVIDED_DIGITAL_CLOCK_DIV
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_arst_n,
    aocl_if.device           link,
    input  wire logic        i_sample_valid,
    input  wire logic [23:0] i_sample,
    output logic             o_two_wire_mode,
    output logic             o_locked,
    output logic [15:0]      o_map_checksum
);
    // register map storage, 8-bit per address (config image)
    logic [7:0]  map_reg [aocl_pkg::MAP_DEPTH];
    logic [7:0]  key_reg;
    logic [7:0]  status_comm_register;
    logic [23:0] first_latch_reg;
    logic [23:0] second_latch_reg;
    logic        sample_ready_flag_reg;
    logic        mode_reg;
    logic        mode_taken_reg;
    logic        sck_d_reg;
    logic [15:0] map_checksum_field;
    logic [15:0] map_ref_reg;
    logic        ref_valid_reg;
    logic        alarm_reg;
    logic [7:0]  div_cnt_reg;
    logic        dm_tick;
    logic [3:0]  period_cnt_reg;
    logic [15:0] calc_reg;
    logic [7:0]  shift_reg;
    logic [2:0]  bit_cnt_reg;
    logic [4:0]  addr_reg;
    logic        rd_reg;
    logic [15:0] comm_checksum_value;
    logic [5:0]  out_cnt_reg;
    aocl_pkg::aocl_state_t state_reg;
    logic        locked;
    logic        sck_rise;
    logic        sck_fall;
    logic        cmd_done;
    logic [15:0] map_crc_calc;
    logic [23:0] key_crc;

    // key byte above checksum field, as read back from the key address
    assign key_crc = {key_reg, map_checksum_field};

    assign locked    = (key_reg != aocl_pkg::UNLOCK_KEY);
    assign sck_rise  = link.sck & ~sck_d_reg & ~link.cs_n;
    assign sck_fall  = ~link.sck & sck_d_reg & ~link.cs_n;
    assign cmd_done  = sck_rise && (bit_cnt_reg == 3'h7) && (state_reg == aocl_pkg::AOCL_CMD);
    assign o_locked  = locked;
    assign o_map_checksum = map_checksum_field;

    // interface choice caught at first edge after reset release
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mode_reg       <= 1'b0;
            mode_taken_reg <= 1'b0;
        end else if (!mode_taken_reg) begin
            mode_taken_reg <= 1'b1;
            mode_reg       <= status_comm_register[aocl_pkg::BIT_EXTERNAL_CLOCK_SELECT]
                              & link.interface_select_pin;
        end
    end
    assign o_two_wire_mode = mode_reg;

    // first latch and ready flag
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            first_latch_reg       <= 24'h000000;
            sample_ready_flag_reg <= 1'b1;
        end else if (i_sample_valid) begin
            first_latch_reg       <= i_sample;
            sample_ready_flag_reg <= 1'b0;
        end else if (state_reg == aocl_pkg::AOCL_DATA && rd_reg && out_cnt_reg == 6'h00) begin
            sample_ready_flag_reg <= 1'b1;
        end
    end

    // sck edge tracking
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) sck_d_reg <= 1'b0;
        else           sck_d_reg <= link.sck;
    end

    // spi engine: command byte, then data words, then checksum
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg           <= aocl_pkg::AOCL_IDLE;
            shift_reg           <= 8'h00;
            bit_cnt_reg         <= 3'h0;
            addr_reg            <= 5'h00;
            rd_reg              <= 1'b0;
            second_latch_reg    <= 24'h000000;
            comm_checksum_value <= aocl_pkg::CRC_INIT;
            out_cnt_reg         <= 6'h00;
            link.sdo            <= 1'b0;
        end else if (link.cs_n) begin
            state_reg   <= aocl_pkg::AOCL_IDLE;
            bit_cnt_reg <= 3'h0;
        end else begin
            case (state_reg)
                aocl_pkg::AOCL_IDLE: begin
                    state_reg <= aocl_pkg::AOCL_CMD;
                end
                aocl_pkg::AOCL_CMD: begin
                    if (sck_rise) begin
                        shift_reg   <= {shift_reg[6:0], link.sdi};
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    end
                    if (cmd_done) begin
                        addr_reg <= shift_reg[4:0];
                        rd_reg   <= link.sdi;
                        comm_checksum_value <= aocl_pkg::CRC_INIT;
                        out_cnt_reg <= 6'd23;
                        second_latch_reg <= first_latch_reg;
                        state_reg <= link.sdi ? aocl_pkg::AOCL_DATA : aocl_pkg::AOCL_DONE;
                    end
                end
                aocl_pkg::AOCL_DATA: begin
                    // reads of ADDR_CONV return the held sample; other addresses return the key byte and map checksum
                    if (rd_reg) begin
                        link.sdo <= (addr_reg == aocl_pkg::ADDR_CONV)
                                    ? second_latch_reg[out_cnt_reg[4:0]]
                                    : key_crc[out_cnt_reg[4:0]];
                        if (sck_fall) begin
                            comm_checksum_value <= aocl_pkg::aocl_crc_bit(comm_checksum_value,
                                link.sdo);
                            if (out_cnt_reg == 6'h00) begin
                                state_reg <= status_comm_register[aocl_pkg::BIT_CRC_EN]
                                    ? aocl_pkg::AOCL_CRC : aocl_pkg::AOCL_CMD;
                                out_cnt_reg <= status_comm_register[aocl_pkg::BIT_WIDTH32]
                                    ? 6'd31 : 6'd15;
                            end else begin
                                out_cnt_reg <= out_cnt_reg - 6'h01;
                            end
                        end
                    end
                end
                aocl_pkg::AOCL_CRC: begin
                    // checksum high byte first, zero padding after sixteen bits
                    link.sdo <= (out_cnt_reg > 6'd15) ? comm_checksum_value[out_cnt_reg[3:0]]
                              : (status_comm_register[aocl_pkg::BIT_WIDTH32] ? 1'b0
                              : comm_checksum_value[out_cnt_reg[3:0]]);
                    if (sck_fall) begin
                        if (out_cnt_reg == 6'h00) begin
                            state_reg   <= aocl_pkg::AOCL_DATA;
                            out_cnt_reg <= 6'd23;
                            second_latch_reg <= first_latch_reg;
                            comm_checksum_value <= aocl_pkg::CRC_INIT;
                        end else begin
                            out_cnt_reg <= out_cnt_reg - 6'h01;
                        end
                    end
                end
                aocl_pkg::AOCL_DONE: begin
                    // write frame: collect the data byte after the command
                    if (sck_rise) begin
                        shift_reg   <= {shift_reg[6:0], link.sdi};
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    end
                end
                default: state_reg <= aocl_pkg::AOCL_IDLE;
            endcase
        end
    end
    assign link.sdo_oe = ~link.cs_n & rd_reg
                         & (state_reg == aocl_pkg::AOCL_DATA || state_reg == aocl_pkg::AOCL_CRC);

    // key and status writes over the link (byte after command)
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            key_reg              <= aocl_pkg::UNLOCK_KEY;
            status_comm_register <= 8'h08;
            for (int i = 0; i < aocl_pkg::MAP_DEPTH; i++) map_reg[i] <= 8'h00;
        end else if (state_reg == aocl_pkg::AOCL_DONE && sck_rise && bit_cnt_reg == 3'h7) begin
            if (addr_reg == aocl_pkg::ADDR_KEY) key_reg <= {shift_reg[6:0], link.sdi};
            else if (!locked && addr_reg >= aocl_pkg::ADDR_MAP_FIRST) begin
                map_reg[addr_reg] <= {shift_reg[6:0], link.sdi};
                if (addr_reg == aocl_pkg::ADDR_MAP_FIRST)
                    status_comm_register <= {shift_reg[6:0], link.sdi};
            end
        end
    end

    // divided digital clock enable
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) div_cnt_reg <= 8'h00;
        else if (dm_tick) div_cnt_reg <= 8'h00;
        else div_cnt_reg <= div_cnt_reg + 8'h01;
    end
    assign dm_tick = (div_cnt_reg == 8'(DIVIDED_DIGITAL_CLOCK_DIV - 1));

    // map checksum over 0x09..0x1f, ready flag as 1, field as 0
    always_comb begin
        map_crc_calc = aocl_pkg::CRC_INIT;
        for (int a = aocl_pkg::ADDR_MAP_FIRST; a < aocl_pkg::MAP_DEPTH - 1; a++)
            for (int b = 7; b >= 0; b--)
                map_crc_calc = aocl_pkg::aocl_crc_bit(map_crc_calc,
                    (a == aocl_pkg::ADDR_MAP_FIRST && b == 7) ? 1'b1 : map_reg[a][b]);
        for (int b = 7; b >= 0; b--)
            map_crc_calc = aocl_pkg::aocl_crc_bit(map_crc_calc, key_reg[b]);
        for (int b = 15; b >= 0; b--)
            map_crc_calc = aocl_pkg::aocl_crc_bit(map_crc_calc, 1'b0);
    end

    // periodic map check, reference and alarm
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            period_cnt_reg     <= 4'h0;
            map_checksum_field <= 16'h0000;
            map_ref_reg        <= 16'h0000;
            ref_valid_reg      <= 1'b0;
            alarm_reg          <= 1'b0;
            calc_reg           <= 16'h0000;
        end else if (!locked) begin
            period_cnt_reg     <= 4'h0;
            map_checksum_field <= 16'h0000;
            ref_valid_reg      <= 1'b0;
            alarm_reg          <= 1'b0;
        end else if (dm_tick) begin
            if (period_cnt_reg == aocl_pkg::MAP_PERIODS_M1) begin
                period_cnt_reg     <= 4'h0;
                calc_reg           <= map_crc_calc;
                map_checksum_field <= map_crc_calc;
                if (!ref_valid_reg) begin
                    map_ref_reg   <= map_crc_calc;
                    ref_valid_reg <= 1'b1;
                end else if (map_crc_calc != map_ref_reg
                             && status_comm_register[aocl_pkg::BIT_INT_EN]) begin
                    alarm_reg <= 1'b1;
                end
            end else begin
                period_cnt_reg <= period_cnt_reg + 4'h1;
            end
        end
    end

    // ready pin low on fresh sample or held alarm
    assign link.sample_ready_pin_n = ~(alarm_reg | i_sample_valid);
endmodule : aocl_device

// file: rtl/aocl_host.sv
`timescale 1ns/1ps
module aocl_host (
    input  wire logic        i_sys_clk,
    input  wire logic        i_arst_n,
    aocl_if.host             link,
    input  wire logic [3:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [23:0]      o_rdata,
    output logic             o_busy
);
    logic [7:0]  cmd_reg;
    logic [23:0] data_reg;
    logic [15:0] crc_reg;
    logic        crc_err_reg;
    logic        go_reg;
    logic [6:0]  cnt_reg;
    logic        div_reg;
    logic        mode_reg;
    logic [7:0]  wbyte_reg;
    logic [15:0] rx_crc_reg;

    // clock is a divider output, master drives sck, cs_n and sdi
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            go_reg <= 1'b0; cnt_reg <= 7'h00; div_reg <= 1'b0;
            link.sck <= 1'b0; link.cs_n <= 1'b1; link.sdi <= 1'b0;
            data_reg <= 24'h000000; crc_reg <= 16'h0000; crc_err_reg <= 1'b0;
            cmd_reg <= 8'h00; mode_reg <= 1'b0;
            wbyte_reg <= 8'h00; rx_crc_reg <= 16'h0000;
        end else if (i_wr && i_addr == aocl_pkg::OFS_CTRL) begin
            cmd_reg <= i_wdata;
            go_reg  <= 1'b1;
            cnt_reg <= 7'h00;
            crc_reg <= aocl_pkg::CRC_INIT;
        end else if (i_wr && i_addr == aocl_pkg::OFS_DATA) begin
            wbyte_reg <= i_wdata;
        end else if (i_wr && i_addr == aocl_pkg::OFS_MAPWR) begin
            mode_reg <= i_wdata[0];
        end else if (go_reg) begin
            link.cs_n <= 1'b0;
            div_reg   <= ~div_reg;
            if (div_reg) begin
                link.sck <= ~link.sck;
                if (link.sck) begin
                    // falling edge: advance bit
                    cnt_reg  <= cnt_reg + 7'h01;
                    link.sdi <= (cnt_reg < 7'd7) ? cmd_reg[3'd6 - cnt_reg[2:0]]
                              : (cnt_reg < 7'd15) ? wbyte_reg[3'd6 - cnt_reg[2:0]] : 1'b0;
                    // write frames stop after the data byte
                    if (cnt_reg == (cmd_reg[0] ? 7'd47 : 7'd15)) begin
                        go_reg    <= 1'b0;
                        link.cs_n <= 1'b1;
                        crc_err_reg <= (crc_reg != aocl_pkg::CRC_GOOD);
                    end
                end else if (cnt_reg >= 7'd8) begin
                    // rising edge: take device data
                    crc_reg <= aocl_pkg::aocl_crc_bit(crc_reg, link.sdo);
                    if (cnt_reg < 7'd32) data_reg <= {data_reg[22:0], link.sdo};
                    else if (cnt_reg < 7'd48) rx_crc_reg <= {rx_crc_reg[14:0], link.sdo};
                end
            end
        end else begin
            link.sck <= 1'b0;
            link.sdi <= cmd_reg[7];
        end
    end
    assign link.interface_select_pin = mode_reg;

    // register read port
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) o_rdata <= 24'h000000;
        else if (i_rd) o_rdata <= (i_addr == aocl_pkg::OFS_STAT)
                                  ? {21'h000000, crc_err_reg, ~link.sample_ready_pin_n, go_reg}
                                  : (i_addr == aocl_pkg::OFS_CRC) ? {8'h00, rx_crc_reg}
                                  : data_reg;
    end
    assign o_busy = go_reg;
endmodule : aocl_host

// file: sim/aocl_monitor.sv
`timescale 1ns/1ps
module aocl_monitor (
    input  wire logic i_sys_clk,
    input  wire logic i_arst_n,
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic sdi,
    input  wire logic sdo,
    input  wire logic sdo_oe,
    input  wire logic sample_ready_pin_n,
    input  wire logic interface_select_pin
);
    logic [6:0]  bit_cnt_reg;
    logic [15:0] crc_reg;
    logic        sck_prev_reg;
    logic        sdo_prev_reg;

    default clocking mon_cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_arst_n);

    // last sck level, to spot rising edges
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sck_prev_reg <= 1'b0;
            sdo_prev_reg <= 1'b0;
        end else begin
            sck_prev_reg <= sck;
            sdo_prev_reg <= sdo; // data as the host saw it at its rising edge
        end
    end

    // count frame bits and run the checksum over all bits after the command byte
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bit_cnt_reg <= 7'h00;
            crc_reg     <= 16'h0000;
        end else if (cs_n) begin
            bit_cnt_reg <= 7'h00;
            crc_reg     <= 16'h0000;
        end else if (sck && !sck_prev_reg) begin
            bit_cnt_reg <= bit_cnt_reg + 7'h01;
            if (bit_cnt_reg >= 7'h08) begin
                crc_reg <= {crc_reg[14:0], 1'b0}
                           ^ ((crc_reg[15] ^ sdo_prev_reg) ? 16'h8005 : 16'h0000);
            end
        end
    end

    AST_SCK_IDLE: assert property (cs_n |-> !sck)
        else $error("serial clock moves outside a frame");
    AST_SCK_HALF: assert property ($rose(sck) |=> sck ##1 !sck)
        else $error("serial clock high phase not two cycles");
    AST_FRAME_BOUND: assert property ($fell(cs_n) |-> ##[1:400] cs_n)
        else $error("frame never ends");
    AST_SDO_RELEASE: assert property ((cs_n && $past(cs_n)) |-> !sdo_oe)
        else $error("data line driven while not selected");
    AST_SDO_HOLD: assert property (($rose(sck) && !cs_n) |=> $stable(sdo))
        else $error("data line changes while clock high");
    AST_BIT_COUNT: assert property ($rose(cs_n) |->
        (bit_cnt_reg == 7'h10 || bit_cnt_reg == 7'h20 || bit_cnt_reg == 7'h30
         || bit_cnt_reg == 7'h40))
        else $error("frame length not 16, 32, 48 or 64 bits");
    AST_CRC_ZERO: assert property (($rose(cs_n) && bit_cnt_reg >= 7'h30) |->
        crc_reg == 16'h0000)
        else $error("checksum remainder not zero");
    AST_PIN_AFTER_RESET: assert property ($rose(i_arst_n) |-> sample_ready_pin_n [*2])
        else $error("ready pin low right after reset");

    // main scenarios
    COV_FRAME48: cover property ($rose(cs_n) && bit_cnt_reg == 7'h30);
    COV_FRAME_START: cover property ($fell(cs_n));
    COV_READY_PULSE: cover property ($fell(sample_ready_pin_n));
endmodule : aocl_monitor

// file: sim/test_adc_output_crc_lock_unit.sv
`timescale 1ns/1ps
module test_adc_output_crc_lock_unit;
    logic        clk;
    logic        rst_host_n;
    logic        rst_dev_n;
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic        sample_valid;
    logic [23:0] sample;
    logic [23:0] rdata;
    logic        busy;
    logic        two_wire;
    logic        locked;
    logic [15:0] map_crc;
    logic [23:0] got;
    int          n_errors;
    int          check_count;

    aocl_if link ();
    aocl_device #(.DIVIDED_DIGITAL_CLOCK_DIV(4)) i_aocl_device (.i_sys_clk(clk), .i_arst_n(rst_dev_n),
        .link(link), .i_sample_valid(sample_valid), .i_sample(sample),
        .o_two_wire_mode(two_wire), .o_locked(locked), .o_map_checksum(map_crc));
    aocl_host i_aocl_host (.i_sys_clk(clk), .i_arst_n(rst_host_n), .link(link),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_busy(busy));
    aocl_monitor i_aocl_monitor (.i_sys_clk(clk), .i_arst_n(rst_dev_n), .sck(link.sck),
        .cs_n(link.cs_n), .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe),
        .sample_ready_pin_n(link.sample_ready_pin_n),
        .interface_select_pin(link.interface_select_pin));

    // 10 MHz system clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic report_and_stop();
        if (n_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : reg_wr

    // read data stand in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, output logic [23:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : reg_rd

    task automatic wait_idle();
        int i;
        repeat (2) @(posedge clk);
        i = 0;
        while (busy === 1'b1 && i < 2000) begin
            @(posedge clk);
            i++;
        end
        if (i >= 2000) begin
            n_errors++;
            $display("BAD %0t transfer never finished", $time);
            report_and_stop();
        end
    endtask : wait_idle

    task automatic push(input logic [23:0] v);
        @(posedge clk);
        sample       <= v;
        sample_valid <= 1'b1;
        @(posedge clk);
        sample_valid <= 1'b0;
    endtask : push

    task automatic dev_reset();
        @(posedge clk);
        rst_dev_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_dev_n <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : dev_reset

    // reference checksum, msb first, zero start
    function automatic logic [15:0] crc_of(input logic [23:0] d);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = 23; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0000);
        end
        return c;
    endfunction : crc_of

    // main sequence
    initial begin
        rst_host_n   = 1'b0;
        rst_dev_n    = 1'b0;
        addr         = 4'h0;
        wdata        = 8'h00;
        wr           = 1'b0;
        rd           = 1'b0;
        sample_valid = 1'b0;
        sample       = 24'h000000;
        n_errors     = 0;
        check_count  = 0;
        repeat (5) @(posedge clk);
        rst_host_n <= 1'b1;
        rst_dev_n  <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({23'h0, link.sample_ready_pin_n}, 24'h000001);
        chk({23'h0, locked}, 24'h000000);
        chk({8'h00, map_crc}, 24'h000000);
        chk({23'h0, two_wire}, 24'h000000);
        // enable the read checksum through the status image
        reg_wr(aocl_pkg::OFS_DATA, 8'h09);
        reg_wr(aocl_pkg::OFS_CTRL, {2'b00, aocl_pkg::ADDR_MAP_FIRST, 1'b0});
        wait_idle();
        // conversion read while a newer sample lands mid-read
        push(24'h5ac396);
        repeat (8) @(posedge clk);
        reg_wr(aocl_pkg::OFS_CTRL, {2'b00, aocl_pkg::ADDR_CONV, 1'b1});
        repeat (60) @(posedge clk);
        push(24'h123456);
        wait_idle();
        reg_rd(aocl_pkg::OFS_DATA, got);
        chk(got, 24'h5ac396);
        reg_rd(aocl_pkg::OFS_CRC, got);
        chk(got, {8'h00, crc_of(24'h5ac396)});
        // next read brings the newer sample
        reg_wr(aocl_pkg::OFS_CTRL, {2'b00, aocl_pkg::ADDR_CONV, 1'b1});
        wait_idle();
        reg_rd(aocl_pkg::OFS_DATA, got);
        chk(got, 24'h123456);
        reg_rd(aocl_pkg::OFS_CRC, got);
        chk(got, {8'h00, crc_of(24'h123456)});
        // lock the map, checksum starts, locked writes are ignored
        reg_wr(aocl_pkg::OFS_DATA, 8'h00);
        reg_wr(aocl_pkg::OFS_CTRL, {2'b00, aocl_pkg::ADDR_KEY, 1'b0});
        wait_idle();
        chk({23'h0, locked}, 24'h000001);
        repeat (60) @(posedge clk);
        @(negedge clk);
        chk({23'h0, map_crc != 16'h0000}, 24'h000001);
        reg_wr(aocl_pkg::OFS_DATA, 8'h08);
        reg_wr(aocl_pkg::OFS_CTRL, {2'b00, aocl_pkg::ADDR_MAP_FIRST, 1'b0});
        wait_idle();
        reg_wr(aocl_pkg::OFS_CTRL, {2'b00, aocl_pkg::ADDR_CONV, 1'b1});
        wait_idle();
        reg_rd(aocl_pkg::OFS_CRC, got);
        chk(got, {8'h00, crc_of(24'h123456)});
        // unlock clears the map checksum
        reg_wr(aocl_pkg::OFS_DATA, 8'ha5);
        reg_wr(aocl_pkg::OFS_CTRL, {2'b00, aocl_pkg::ADDR_KEY, 1'b0});
        wait_idle();
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({23'h0, locked}, 24'h000000);
        chk({8'h00, map_crc}, 24'h000000);
        // unmapped write starts nothing
        reg_wr(4'he, 8'hff);
        reg_rd(aocl_pkg::OFS_STAT, got);
        chk({23'h0, got[0]}, 24'h000000);
        // interface choice follows the pin only at reset release
        reg_wr(aocl_pkg::OFS_MAPWR, 8'h01);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk({23'h0, two_wire}, 24'h000000);
        dev_reset();
        chk({23'h0, two_wire}, 24'h000001);
        chk({8'h00, map_crc}, 24'h000000);
        reg_wr(aocl_pkg::OFS_MAPWR, 8'h00);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk({23'h0, two_wire}, 24'h000001);
        dev_reset();
        chk({23'h0, two_wire}, 24'h000000);
        report_and_stop();
    end
endmodule : test_adc_output_crc_lock_unit
